// ---- design/csi_pkg.sv ----
// constants, types and layouts for the processor's console service unit
// assumes the console answers device address 0 on the shared system bus
package csi_pkg;
  // device address and function codes of the console
  localparam logic [5:0] CON_DEV_ADDR = 6'h00;
  localparam logic [2:0] FC_STATUS = 3'h0;
  localparam logic [2:0] FC_SENSE = 3'h1;
  localparam logic [2:0] FC_DATA = 3'h4;
  // console control word codes
  localparam logic [15:0] CCW_STOP = 16'h1C00;
  localparam logic [15:0] CCW_MEM_RD = 16'h1C02;
  localparam logic [15:0] CCW_MEM_WR = 16'h1C03;
  localparam logic [15:0] CCW_A_OUT = 16'h1C04;
  localparam logic [15:0] CCW_A_IN = 16'h1C05;
  localparam logic [15:0] CCW_X_OUT = 16'h1C08;
  localparam logic [15:0] CCW_X_IN = 16'h1C09;
  localparam logic [15:0] CCW_I_OUT = 16'h1C10;
  localparam logic [15:0] CCW_I_IN = 16'h1C11;
  localparam logic [15:0] CCW_P_OUT = 16'h1C20;
  localparam logic [15:0] CCW_P_IN = 16'h1C21;
  // control word fields: modifier bits low, operation code high
  localparam int CCW_MOD_MSB = 5;
  localparam int CCW_OP_LSB = 6;
  // status word field positions
  localparam int SW_PROC_MSB = 2;
  localparam int SW_SENSE_SW_BIT = 3;
  localparam int SW_SENSE_LSB = 4;
  localparam int SW_SENSE_MSB = 7;
  localparam int SENSE_MSB = 3;
  // reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  // bus strobe timing
  localparam int CLK_NS = 4;
  localparam int STROBE_NS = 400;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC - 1);

  // processor register selection
  typedef enum logic [1:0] {
    CSI_REG_A,
    CSI_REG_X,
    CSI_REG_I,
    CSI_REG_P
  } csi_reg_e;

  // programmed console transfers the core may request
  typedef enum logic [2:0] {
    CSI_IO_STATUS_IN,
    CSI_IO_STATUS_OUT,
    CSI_IO_SENSE_IN,
    CSI_IO_DATA_IN,
    CSI_IO_DATA_OUT
  } csi_io_e;

  // bus control lines, active low strobes
  typedef struct packed {
    logic [5:0] dev_addr;
    logic [2:0] func;
    logic in_n;
    logic out_n;
    logic fetch_n;
  } csi_bus_s;

  // decoded control word
  typedef struct packed {
    logic stop;
    logic mem;
    logic to_cpu;
    csi_reg_e sel;
  } csi_ccw_s;
endpackage

// ---- design/csi_reg_bank.sv ----
// processor working registers a, x, i and p with a registered read port
// assumes one writer per cycle, chosen by the console unit
`timescale 1ns/1ns
`default_nettype none
module csi_reg_bank
  import csi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic we,
  input wire csi_pkg::csi_reg_e wsel,
  input wire logic [15:0] wdata,
  input wire csi_pkg::csi_reg_e rsel,
  input wire logic pc_inc,
  output logic [15:0] rdata,
  output logic [15:0] pc
);
  logic [15:0] regs_ff [4];
  logic [15:0] rdata_ff;

  // register writes; a write to p wins over an increment
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        regs_ff[i] <= WORD_RST;
      end
    end else begin
      if (we) begin
        regs_ff[wsel] <= wdata;
      end
      if (pc_inc && !(we && wsel == CSI_REG_P)) begin
        regs_ff[CSI_REG_P] <= regs_ff[CSI_REG_P] + 16'h0001;
      end
    end
  end

  // read data one cycle after the select
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= WORD_RST;
    end else begin
      rdata_ff <= regs_ff[rsel];
    end
  end

  assign rdata = rdata_ff;
  assign pc = regs_ff[CSI_REG_P];
endmodule
`default_nettype wire

// ---- design/csi_console_unit.sv ----
// processor side of the console link: service fetch, control word execution
// assumes console pins arrive asynchronously and memory answers on sys_clk
// What this block does
// - status word moves only with fetch envelope inactive, address 0, function 0
// - status input takes bit 3 and bits 4-7 from console, bits 0-2 internally
// - status output carries sense switch on bit 3, sense bits on 4-7
// - sense word other bits read zero; no output issued for it
// - data word is 16-bit, moved by function 4 input or output
// - service sequence moves data word to or from a, x, i, p or memory
// - control word is an instruction: opcode bits 6-15, modifiers 0-5
// - eleven control words decoded, halt after each, memory ones step p
// - service request honoured after current instruction, fetch from console
// - stop control word brings processor to stopped condition
// - processor resumes on rising edge of resume pulse
`timescale 1ns/1ns
`default_nettype none
module csi_console_unit
  import csi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  // console pins, asynchronous
  input wire logic console_service_request_n,
  input wire logic resume_n,
  input wire logic operator_interrupt_request_n,
  input wire logic sense_switch_line_n,
  input wire logic [15:0] bus_data_in,
  // bus toward the console
  output csi_pkg::csi_bus_s bus_ctl,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe_n,
  output logic interrupt_acknowledge_n,
  // core side
  input wire logic instr_done,
  input wire logic [2:0] proc_status,
  input wire logic int_ack,
  input wire logic io_req,
  input wire csi_pkg::csi_io_e io_op,
  input wire logic [15:0] io_wdata,
  output logic io_done,
  output logic [15:0] io_rdata,
  output logic core_run,
  output logic sense_switch_set,
  output logic operator_int_pending,
  input wire logic core_reg_we,
  input wire csi_pkg::csi_reg_e core_reg_sel,
  input wire logic [15:0] core_reg_wdata,
  output logic [15:0] core_reg_rdata,
  // memory port
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  typedef enum logic [3:0] {
    ST_RUN, ST_BUS, ST_DECODE, ST_RDREG, ST_RDLAT, ST_MEMRD, ST_MEMWR,
    ST_WRREG, ST_HALT
  } csi_state_e;

  // decode a control word; unknown codes act as stop
  function automatic csi_ccw_s decode_ccw(input logic [15:0] w);
    csi_ccw_s d;
    d = '{stop: 1'b0, mem: 1'b0, to_cpu: 1'b0, sel: CSI_REG_A};
    unique case (w)
      CCW_MEM_RD, CCW_MEM_WR: d.mem = 1'b1;
      CCW_A_OUT, CCW_A_IN: d.sel = CSI_REG_A;
      CCW_X_OUT, CCW_X_IN: d.sel = CSI_REG_X;
      CCW_I_OUT, CCW_I_IN: d.sel = CSI_REG_I;
      CCW_P_OUT, CCW_P_IN: d.sel = CSI_REG_P;
      default: d.stop = 1'b1;
    endcase
    // odd codes carry the console word into the processor
    d.to_cpu = w[0] && !d.stop;
    return d;
  endfunction

  csi_state_e state_ff, ret_ff;
  logic [19:0] sync1_ff, sync2_ff;
  logic resume_prev_ff;
  logic [7:0] cnt_ff;
  logic [15:0] ccw_ff, xfer_ff, io_rdata_ff;
  logic from_core_ff, io_done_ff, pc_inc_ff;
  csi_io_e op_ff;
  csi_bus_s bus_ff;
  logic [15:0] data_out_ff;
  logic oe_n_ff, mem_req_ff, mem_we_ff, int_ack_n_ff;
  csi_ccw_s ccw_dec;
  logic svc_active, resume_rise;
  logic bank_we;
  csi_reg_e bank_wsel;
  logic [15:0] bank_wdata, bank_rdata, pc;

  // two-stage synchronisers for every console pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_ff <= 20'h0_000F;
      sync2_ff <= 20'h0_000F;
      resume_prev_ff <= 1'b1;
    end else begin
      sync1_ff <= {bus_data_in, console_service_request_n, resume_n,
                   operator_interrupt_request_n, sense_switch_line_n};
      sync2_ff <= sync1_ff;
      resume_prev_ff <= sync2_ff[2];
    end
  end

  assign svc_active = !sync2_ff[3];
  assign resume_rise = sync2_ff[2] && !resume_prev_ff;
  assign ccw_dec = decode_ccw(ccw_ff);

  // sequencer: run, service fetch, control word execution, halt
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= ST_HALT;
      ret_ff <= ST_HALT;
      cnt_ff <= 8'h00;
      ccw_ff <= CCW_STOP;
      xfer_ff <= WORD_RST;
      from_core_ff <= 1'b0;
      op_ff <= CSI_IO_STATUS_IN;
      bus_ff <= '{dev_addr: CON_DEV_ADDR, func: FC_STATUS, in_n: 1'b1,
                  out_n: 1'b1, fetch_n: 1'b1};
      data_out_ff <= WORD_RST;
      oe_n_ff <= 1'b1;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      io_done_ff <= 1'b0;
      io_rdata_ff <= WORD_RST;
      pc_inc_ff <= 1'b0;
    end else begin
      io_done_ff <= 1'b0;
      pc_inc_ff <= 1'b0;
      unique case (state_ff)
        ST_RUN: begin
          if (instr_done && svc_active) begin
            // control word fetch: envelope on, address 0, function 0
            bus_ff <= '{dev_addr: CON_DEV_ADDR, func: FC_STATUS, in_n: 1'b0,
                        out_n: 1'b1, fetch_n: 1'b0};
            from_core_ff <= 1'b0;
            ret_ff <= ST_DECODE;
            cnt_ff <= STROBE_CNT;
            state_ff <= ST_BUS;
          end else if (io_req) begin
            // programmed console transfer, envelope stays inactive
            op_ff <= io_op;
            from_core_ff <= 1'b1;
            ret_ff <= ST_RUN;
            cnt_ff <= STROBE_CNT;
            state_ff <= ST_BUS;
            unique case (io_op)
              CSI_IO_STATUS_IN, CSI_IO_STATUS_OUT: bus_ff.func <= FC_STATUS;
              CSI_IO_SENSE_IN: bus_ff.func <= FC_SENSE;
              CSI_IO_DATA_IN, CSI_IO_DATA_OUT: bus_ff.func <= FC_DATA;
            endcase
            bus_ff.dev_addr <= CON_DEV_ADDR;
            bus_ff.fetch_n <= 1'b1;
            bus_ff.in_n <= (io_op == CSI_IO_STATUS_OUT || io_op == CSI_IO_DATA_OUT);
            bus_ff.out_n <= !(io_op == CSI_IO_STATUS_OUT || io_op == CSI_IO_DATA_OUT);
            oe_n_ff <= !(io_op == CSI_IO_STATUS_OUT || io_op == CSI_IO_DATA_OUT);
            data_out_ff <= io_wdata;
          end
        end
        ST_BUS: begin
          if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            bus_ff.in_n <= 1'b1;
            bus_ff.out_n <= 1'b1;
            bus_ff.fetch_n <= 1'b1;
            oe_n_ff <= 1'b1;
            state_ff <= ret_ff;
            if (ret_ff == ST_DECODE) begin
              ccw_ff <= sync2_ff[19:4];
            end else begin
              xfer_ff <= sync2_ff[19:4];
            end
            if (from_core_ff) begin
              io_done_ff <= 1'b1;
              unique case (op_ff)
                CSI_IO_STATUS_IN: begin
                  io_rdata_ff <= WORD_RST;
                  io_rdata_ff[SW_SENSE_MSB:SW_SENSE_SW_BIT] <=
                    sync2_ff[4+SW_SENSE_MSB:4+SW_SENSE_SW_BIT];
                  io_rdata_ff[SW_PROC_MSB:0] <= proc_status;
                end
                CSI_IO_SENSE_IN: begin
                  io_rdata_ff <= WORD_RST;
                  io_rdata_ff[SENSE_MSB:0] <= sync2_ff[4+SENSE_MSB:4];
                end
                CSI_IO_DATA_IN: io_rdata_ff <= sync2_ff[19:4];
                default: io_rdata_ff <= io_rdata_ff;
              endcase
            end
          end
        end
        ST_DECODE: begin
          from_core_ff <= 1'b0;
          bus_ff.func <= FC_DATA;
          if (ccw_dec.stop) begin
            state_ff <= ST_HALT;
          end else if (ccw_dec.mem && !ccw_dec.to_cpu) begin
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b0;
            state_ff <= ST_MEMRD;
          end else if (ccw_dec.to_cpu) begin
            bus_ff.in_n <= 1'b0;
            ret_ff <= ccw_dec.mem ? ST_MEMWR : ST_WRREG;
            cnt_ff <= STROBE_CNT;
            state_ff <= ST_BUS;
          end else begin
            state_ff <= ST_RDREG;
          end
        end
        ST_RDREG: state_ff <= ST_RDLAT;
        ST_RDLAT: begin
          xfer_ff <= bank_rdata;
          data_out_ff <= bank_rdata;
          bus_ff.out_n <= 1'b0;
          oe_n_ff <= 1'b0;
          ret_ff <= ST_HALT;
          cnt_ff <= STROBE_CNT;
          state_ff <= ST_BUS;
        end
        ST_MEMRD: begin
          if (mem_ack) begin
            mem_req_ff <= 1'b0;
            pc_inc_ff <= 1'b1;
            data_out_ff <= mem_rdata;
            bus_ff.out_n <= 1'b0;
            oe_n_ff <= 1'b0;
            ret_ff <= ST_HALT;
            cnt_ff <= STROBE_CNT;
            state_ff <= ST_BUS;
          end
        end
        ST_MEMWR: begin
          mem_req_ff <= 1'b1;
          mem_we_ff <= 1'b1;
          if (mem_req_ff && mem_ack) begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            pc_inc_ff <= 1'b1;
            state_ff <= ST_HALT;
          end
        end
        ST_WRREG: state_ff <= ST_HALT;
        ST_HALT: begin
          if (resume_rise) begin
            if (svc_active) begin
              bus_ff <= '{dev_addr: CON_DEV_ADDR, func: FC_STATUS, in_n: 1'b0,
                          out_n: 1'b1, fetch_n: 1'b0};
              from_core_ff <= 1'b0;
              ret_ff <= ST_DECODE;
              cnt_ff <= STROBE_CNT;
              state_ff <= ST_BUS;
            end else begin
              state_ff <= ST_RUN;
            end
          end
        end
        default: state_ff <= ST_HALT;
      endcase
    end
  end

  // interrupt acknowledge pin follows the core's acknowledge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_ack_n_ff <= 1'b1;
    end else begin
      int_ack_n_ff <= !int_ack;
    end
  end

  // register bank: console unit owns it while stopped, core while running
  assign bank_we = (state_ff == ST_RUN) ? core_reg_we : (state_ff == ST_WRREG);
  assign bank_wsel = (state_ff == ST_RUN) ? core_reg_sel : ccw_dec.sel;
  assign bank_wdata = (state_ff == ST_RUN) ? core_reg_wdata : xfer_ff;

  csi_reg_bank u_bank (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .we(bank_we),
    .wsel(bank_wsel),
    .wdata(bank_wdata),
    .rsel((state_ff == ST_RUN) ? core_reg_sel : ccw_dec.sel),
    .pc_inc(pc_inc_ff),
    .rdata(bank_rdata),
    .pc(pc)
  );

  assign bus_ctl = bus_ff;
  assign bus_data_out = data_out_ff;
  assign bus_data_oe_n = oe_n_ff;
  assign interrupt_acknowledge_n = int_ack_n_ff;
  assign io_done = io_done_ff;
  assign io_rdata = io_rdata_ff;
  assign core_run = (state_ff == ST_RUN);
  assign sense_switch_set = !sync2_ff[0];
  assign operator_int_pending = !sync2_ff[1];
  assign core_reg_rdata = bank_rdata;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_addr = pc;
  assign mem_wdata = xfer_ff;
endmodule
`default_nettype wire

// ---- test/csi_console_unit_props.sv ----
// checker on the console unit ports: strobes, codes, read words, memory hold
// assumes binding onto csi_console_unit, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module csi_console_unit_props
  import csi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire csi_pkg::csi_bus_s bus_ctl,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_data_oe_n,
  input wire logic io_req,
  input wire csi_pkg::csi_io_e io_op,
  input wire logic [15:0] io_wdata,
  input wire logic io_done,
  input wire logic [15:0] io_rdata,
  input wire logic core_run,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [15:0] mem_addr
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic strobe;
  logic [7:0] len_ff;
  // cycles since the current strobe opened
  assign strobe = !bus_ctl.in_n || !bus_ctl.out_n;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !strobe) begin
      len_ff <= 8'h00;
    end else begin
      len_ff <= len_ff + 8'h01;
    end
  end
  sequence s_req(csi_io_e op);
    io_req && core_run && io_op == op;
  endsequence
  sequence s_in_end(logic [2:0] fc);
    $rose(bus_ctl.in_n) && $past(bus_ctl.fetch_n) && bus_ctl.func == fc;
  endsequence
  property p_status_in;
    s_req(CSI_IO_STATUS_IN) |=> !bus_ctl.in_n && bus_ctl.fetch_n && bus_ctl.func == FC_STATUS
      && bus_ctl.dev_addr == CON_DEV_ADDR;
  endproperty
  property p_status_out;
    s_req(CSI_IO_STATUS_OUT) |=> !bus_ctl.out_n && !bus_data_oe_n
      && bus_ctl.func == FC_STATUS && bus_data_out[7:3] == $past(io_wdata[7:3]);
  endproperty
  property p_sense_in;
    s_req(CSI_IO_SENSE_IN) |=> !bus_ctl.in_n && bus_ctl.func == FC_SENSE;
  endproperty
  property p_data_in;
    s_req(CSI_IO_DATA_IN) |=> !bus_ctl.in_n && bus_ctl.func == FC_DATA;
  endproperty
  property p_data_out;
    s_req(CSI_IO_DATA_OUT) |=> !bus_ctl.out_n && bus_ctl.func == FC_DATA
      && bus_data_out == $past(io_wdata);
  endproperty
  property p_no_sense_out;
    !bus_ctl.out_n |-> bus_ctl.func != FC_SENSE && bus_ctl.in_n;
  endproperty
  property p_status_word;
    s_in_end(FC_STATUS) |-> io_done && io_rdata[15:8] == 8'h00;
  endproperty
  property p_sense_word;
    s_in_end(FC_SENSE) |-> io_done && io_rdata[15:4] == 12'h000;
  endproperty
  property p_fetch;
    $fell(bus_ctl.fetch_n) |-> !bus_ctl.in_n && bus_ctl.out_n && bus_ctl.func == FC_STATUS
      && bus_ctl.dev_addr == CON_DEV_ADDR;
  endproperty
  property p_strobe_len;
    strobe |-> len_ff < 8'(STROBE_CYC);
  endproperty
  property p_strobe_end;
    !strobe && $past(strobe) |-> len_ff == 8'(STROBE_CYC);
  endproperty
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
  endproperty
  a_status_in: assert property (p_status_in)
    else $error("status input strobe wrong");
  a_status_out: assert property (p_status_out)
    else $error("status output strobe or bits wrong");
  a_sense_in: assert property (p_sense_in)
    else $error("sense input strobe wrong");
  a_data_in: assert property (p_data_in)
    else $error("data input strobe wrong");
  a_data_out: assert property (p_data_out)
    else $error("data output strobe or word wrong");
  a_no_sense_out: assert property (p_no_sense_out)
    else $error("output issued with sense code or beside input");
  a_status_word: assert property (p_status_word)
    else $error("status word upper byte not zero");
  a_sense_word: assert property (p_sense_word)
    else $error("sense word upper bits not zero");
  a_fetch: assert property (p_fetch)
    else $error("control word fetch not an input at code zero");
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe held too long");
  a_strobe_end: assert property (p_strobe_end)
    else $error("strobe closed early");
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped before acknowledge");
endmodule
bind csi_console_unit csi_console_unit_props i_props (.sys_clk, .rst_n, .bus_ctl,
  .bus_data_out, .bus_data_oe_n, .io_req, .io_op, .io_wdata, .io_done, .io_rdata,
  .core_run, .mem_req, .mem_ack, .mem_addr);
`default_nettype wire

// ---- test/csi_console_model.sv ----
// operator console model: panel bits, entry and holding words, control words
// assumes the unit strobes device 0; released lines read false via pull-ups
`timescale 1ns/1ns
`default_nettype none
module csi_console_model
  import csi_pkg::*;
(
  input wire logic sys_clk,
  input wire csi_pkg::csi_bus_s bus_ctl,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_data_oe_n,
  input wire logic interrupt_acknowledge_n,
  output logic console_service_request_n,
  output logic resume_n,
  output logic operator_interrupt_request_n,
  output logic sense_switch_line_n,
  output logic [15:0] bus_data_in
);
  logic [3:0] sense = 4'h0;
  logic ssw = 1'b0;
  logic [15:0] entry = 16'h0000;
  logic [15:0] holding = 16'h0000;
  logic [15:0] console_control_word = CCW_STOP;
  initial begin
    console_service_request_n = 1'b1;
    resume_n = 1'b1;
    operator_interrupt_request_n = 1'b1;
    bus_data_in = 16'h0000;
  end
  assign sense_switch_line_n = !ssw;
  // drivers enabled only while addressed by an input strobe
  always @(negedge sys_clk) begin
    if (bus_ctl.in_n || bus_ctl.dev_addr != CON_DEV_ADDR) begin
      bus_data_in <= 16'h0000;
    end else if (bus_ctl.func == FC_STATUS && !bus_ctl.fetch_n) begin
      bus_data_in <= console_control_word;
    end else if (bus_ctl.func == FC_STATUS) begin
      bus_data_in <= {8'h00, sense, ssw, 3'b000};
    end else if (bus_ctl.func == FC_SENSE) begin
      bus_data_in <= {12'h000, sense};
    end else if (bus_ctl.func == FC_DATA) begin
      bus_data_in <= entry;
    end else begin
      bus_data_in <= 16'h0000;
    end
  end
  // receivers: panel bits and holding word
  always @(posedge sys_clk) begin
    if (!bus_ctl.out_n && !bus_data_oe_n && bus_ctl.dev_addr == CON_DEV_ADDR) begin
      if (bus_ctl.func == FC_STATUS) begin
        {sense, ssw} <= bus_data_out[7:3];
      end else if (bus_ctl.func == FC_DATA) begin
        holding <= bus_data_out;
      end
    end
  end
  // one strobe opens and closes, bounded
  task automatic strobe_end();
    int n = 0;
    while (bus_ctl.in_n && bus_ctl.out_n && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    while ((!bus_ctl.in_n || !bus_ctl.out_n) && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic start();
    @(negedge sys_clk);
    resume_n = 1'b0;
    repeat (400) @(negedge sys_clk);
    resume_n = 1'b1;
  endtask
  // service request; non-stop words only from stop mode, with resume
  task automatic serve(input logic [15:0] code);
    console_control_word = code;
    @(negedge sys_clk);
    console_service_request_n = 1'b0;
    if (code != CCW_STOP) begin
      start();
    end
    strobe_end();
    console_service_request_n = 1'b1;
    if (code != CCW_STOP) begin
      strobe_end();
    end
  endtask
  task automatic interrupt();
    int n = 0;
    @(negedge sys_clk);
    operator_interrupt_request_n = 1'b0;
    while (interrupt_acknowledge_n && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    operator_interrupt_request_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// testbench for the console unit: programmed transfers and control words
// assumes the console model on the bus and a slow memory modelled here
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import csi_pkg::*;
  logic sys_clk;
  logic rst_n = 1'b0;
  csi_bus_s bus_ctl;
  logic [15:0] bus_data_in, bus_data_out, io_rdata, core_reg_rdata, mem_addr, mem_wdata;
  logic console_service_request_n, resume_n, operator_interrupt_request_n;
  logic sense_switch_line_n, bus_data_oe_n, interrupt_acknowledge_n, io_done, core_run;
  logic sense_switch_set, operator_int_pending, mem_req, mem_we;
  logic instr_done = 1'b0;
  logic [2:0] proc_status = 3'b101;
  logic int_ack = 1'b0;
  logic io_req = 1'b0;
  csi_io_e io_op = CSI_IO_STATUS_IN;
  logic [15:0] io_wdata = 16'h0000;
  logic mem_ack = 1'b0;
  logic [15:0] mem_rdata = 16'h0000;
  logic [15:0] mem [4];
  logic [1:0] mwait = 2'h0;
  int run_lamp = 0;
  int num_errors = 0;
  int compares = 0;
  logic [15:0] sw [2] = '{16'hFF58, 16'h0030};
  logic [15:0] regs [4] = '{CCW_A_OUT, CCW_X_OUT, CCW_I_OUT, CCW_P_OUT};
  logic [15:0] vals [4] = '{16'h5AA5, 16'h0FF0, 16'h8001, 16'h0002};
  csi_console_unit i_csi_console_unit (.sys_clk, .rst_n, .console_service_request_n,
    .resume_n, .operator_interrupt_request_n, .sense_switch_line_n, .bus_data_in, .bus_ctl,
    .bus_data_out, .bus_data_oe_n, .interrupt_acknowledge_n, .instr_done, .proc_status,
    .int_ack, .io_req, .io_op, .io_wdata, .io_done, .io_rdata, .core_run, .sense_switch_set,
    .operator_int_pending, .core_reg_we(1'b0), .core_reg_sel(CSI_REG_A),
    .core_reg_wdata(16'h0000), .core_reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);
  csi_console_model i_console (.sys_clk, .bus_ctl, .bus_data_out, .bus_data_oe_n,
    .interrupt_acknowledge_n, .console_service_request_n, .resume_n,
    .operator_interrupt_request_n, .sense_switch_line_n, .bus_data_in);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // slow memory: acknowledge on the fourth cycle of a request; run lamp timer
  always @(negedge sys_clk) begin
    run_lamp <= mem_req ? 125000 : (run_lamp > 0 ? run_lamp - 1 : 0);
    mem_ack <= 1'b0;
    if (mem_req && !mem_ack) begin
      mwait <= mwait + 2'h1;
      if (mwait == 2'h3) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[1:0]];
        if (mem_we) begin
          mem[mem_addr[1:0]] <= mem_wdata;
        end
      end
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one programmed transfer, waiting for its completion pulse
  task automatic xfer(input csi_io_e op, input logic [15:0] wd);
    int n = 0;
    @(negedge sys_clk);
    io_op = op;
    io_wdata = wd;
    io_req = 1'b1;
    @(negedge sys_clk);
    io_req = 1'b0;
    while (!io_done && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    check("io_done", 16'(io_done), 16'h0001);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    check("core_run", 16'(core_run), 16'h0000);
    i_console.start();
    repeat (20) @(negedge sys_clk);
    check("core_run", 16'(core_run), 16'h0001);
    i_console.sense = 4'hA;
    i_console.ssw = 1'b1;
    repeat (10) @(negedge sys_clk);
    check("sense_switch_set", 16'(sense_switch_set), 16'h0001);
    xfer(CSI_IO_STATUS_IN, 16'h0000);
    check("status word", io_rdata, 16'h00AD);
    xfer(CSI_IO_SENSE_IN, 16'h0000);
    check("sense word", io_rdata, 16'h000A);
    foreach (sw[k]) begin
      xfer(CSI_IO_STATUS_OUT, sw[k]);
      check("panel bits", 16'({i_console.sense, i_console.ssw}), 16'(sw[k][7:3]));
      repeat (10) @(negedge sys_clk);
      xfer(CSI_IO_STATUS_IN, 16'h0000);
      check("status word", io_rdata, {8'h00, sw[k][7:3], proc_status});
    end
    i_console.entry = 16'hBEEF;
    xfer(CSI_IO_DATA_IN, 16'h0000);
    check("data word", io_rdata, 16'hBEEF);
    xfer(CSI_IO_DATA_OUT, 16'h1234);
    check("holding word", i_console.holding, 16'h1234);
    fork
      i_console.interrupt();
      begin
        repeat (10) @(negedge sys_clk);
        check("int pending", 16'(operator_int_pending), 16'h0001);
        int_ack = 1'b1;
      end
    join
    int_ack = 1'b0;
    // finishing an instruction with no service pending keeps running
    instr_done = 1'b1;
    @(negedge sys_clk);
    instr_done = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("fetch strobe", 16'(bus_ctl.fetch_n), 16'h0001);
    fork
      i_console.serve(CCW_STOP);
      begin
        repeat (410) @(negedge sys_clk);
        instr_done = 1'b1;
        @(negedge sys_clk);
        instr_done = 1'b0;
      end
    join
    repeat (5) @(negedge sys_clk);
    check("core_run", 16'(core_run), 16'h0000);
    // enter each register (output code plus one), then display it
    foreach (regs[k]) begin
      i_console.entry = vals[k];
      i_console.serve(regs[k] | 16'h0001);
      i_console.serve(regs[k]);
      check("register word", i_console.holding, vals[k]);
    end
    i_console.entry = 16'hC0DE;
    i_console.serve(CCW_MEM_WR);
    repeat (20) @(negedge sys_clk);
    check("memory word", mem[2], 16'hC0DE);
    check("run lamp", 16'(run_lamp != 0), 16'h0001);
    i_console.serve(CCW_P_OUT);
    check("program counter", i_console.holding, 16'h0003);
    i_console.entry = 16'h0002;
    i_console.serve(CCW_P_IN);
    i_console.serve(CCW_MEM_RD);
    check("memory word", i_console.holding, 16'hC0DE);
    i_console.serve(CCW_P_OUT);
    check("program counter", i_console.holding, 16'h0003);
    // system reset from the console while stopped, held 5 us
    rst_n = 1'b0;
    repeat (1250) @(negedge sys_clk);
    rst_n = 1'b1;
    check("core_run", 16'(core_run), 16'h0000);
    i_console.serve(CCW_P_OUT);
    check("program counter", i_console.holding, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
